// *** core/sfp_pkg.sv ***
// Shared constants and types of the serial flash protect/read/erase core.
// Assumes a 50 MHz core clock; opcode values are the block's own choice.
package sfp_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int STATUS_WRITE_TIME_NS = 2000;
    localparam int STATUS_WRITE_CYCLES =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------------
    // Status byte layout and reset values
    // ------------------------------------------------------------------
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_ARM_POS = 1;
    localparam int STAT_GUARD_LSB = 2;
    localparam int STAT_LOCK_POS = 7;
    localparam logic RST_LOCK = 1'h0;
    localparam logic RST_ARM = 1'h0;

    // ------------------------------------------------------------------
    // Array geometry and framing
    // ------------------------------------------------------------------
    localparam int SECTOR_LSB = 12;
    localparam int BLOCK_LSB = 16;
    localparam logic [1:0] ADDR_LAST_BYTE = 2'h2;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'h7;
    localparam logic [2:0] DUAL_LAST_PAIR = 3'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    // ------------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_WRITE_ARM = 8'h06;
    localparam logic [7:0] OP_WRITE_DISARM = 8'h04;
    localparam logic [7:0] OP_STATUS_READ = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE = 8'h60;

    typedef enum logic [2:0] {
        ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_STAT, ST_SRIN, ST_DONE, ST_IGNORE
    } sfp_state_e;

    typedef enum logic [2:0] {
        JOB_NONE, JOB_ARM, JOB_DISARM, JOB_STATUS, JOB_SECTOR, JOB_BLOCK, JOB_CHIP
    } sfp_job_e;

endpackage

// *** core/sfp_flash_core.sv ***
// Command logic of a serial NOR flash slave: protection, reads, erases.
// Assumes SPI mode 0 pins sampled by a core clock at least 6x the link clock.
//
// What this block does
// - Lock clear: armed status write accepted unless busy
// - Lock set, protect pin high: write accepted
// - Lock set, protect pin low: write rejected
// - Hard guard whenever lock set and pin low
// - Guarded region refuses erase in both modes
// - Four guard bits large part, three small
// - Address sampled rising, data shifted falling
// - Read address increments per byte, wraps zero
// - Fast and dual reads rejected while busy
// - Dual read puts two bits per edge
// - Everything else stays single-bit output
// - Sector erase fills 4K sector with ones
// - Block erase fills 64K block with ones
// - Erase needs select rise on byte boundary
// - Cycle starts on select rise; busy; latch clears
// - Busy flag readable by status read meanwhile
// - Guarded sector or block never erased
// - Chip erase only when guard bits zero
// - Status write changes only lock, guard bits
// - Refused erase leaves write latch unchanged
`timescale 1ns/1ps

module sfp_flash_core #(
    parameter int ADDR_W = 21,
    parameter int BP_BITS = 4
) (
    input wire logic CORE_CLK_IN,
    input wire logic NRST_IN,
    input wire logic CS_N_IN,
    input wire logic SCLK_IN,
    input wire logic SIO0_IN,
    input wire logic WP_N_IN,
    output logic SIO0_OUT,
    output logic SIO0_OE_N_OUT,
    output logic SIO1_OUT,
    output logic SIO1_OE_N_OUT,
    output logic LOCK_BIT_OUT,
    output logic [BP_BITS-1:0] GUARD_BITS_OUT,
    output logic ARM_LATCH_OUT,
    output logic BUSY_OUT,
    output logic HARD_GUARD_OUT
);

    localparam int NBLK_W = ADDR_W - sfp_pkg::BLOCK_LSB;
    localparam logic [ADDR_W-1:0] SECT_MASK = ADDR_W'((64'h1 << sfp_pkg::SECTOR_LSB) - 1);
    localparam logic [ADDR_W-1:0] BLK_MASK = ADDR_W'((64'h1 << sfp_pkg::BLOCK_LSB) - 1);
    localparam logic [ADDR_W-1:0] SRW_LAST = ADDR_W'(sfp_pkg::STATUS_WRITE_CYCLES - 1);

    // ------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic [1:0] prev_q;
    logic cs_n_s, sclk_s, si_s, wp_n_s;

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            sync1_q <= 4'hB;
            sync2_q <= 4'hB;
            prev_q <= 2'h2;
        end
        else
        begin
            sync1_q <= {CS_N_IN, SCLK_IN, SIO0_IN, WP_N_IN};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[3:2];
        end
    end

    assign cs_n_s = sync2_q[3];
    assign sclk_s = sync2_q[2];
    assign si_s = sync2_q[1];
    assign wp_n_s = sync2_q[0];
    wire sclk_rise = sclk_s && !prev_q[0] && !cs_n_s;
    wire sclk_fall = !sclk_s && prev_q[0] && !cs_n_s;
    wire cs_rise = cs_n_s && !prev_q[1];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    sfp_pkg::sfp_state_e state_q, state_d;
    sfp_pkg::sfp_job_e job_q, job_d;
    logic fast_q, fast_d, dual_q, dual_d;
    logic [2:0] bit_cnt_q;
    logic [1:0] byte_cnt_q;
    logic [7:0] in_sh_q;
    logic [7:0] out_sh_q;
    logic [2:0] out_cnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic lock_q, arm_q, busy_q, er_wr_q, hard_q;
    logic [BP_BITS-1:0] guard_q;
    logic [ADDR_W-1:0] er_ptr_q, er_end_q;
    logic sio0_q, sio0_oe_n_q, sio1_q, sio1_oe_n_q;
    logic [7:0] flash_array [0:(1 << ADDR_W)-1];

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    wire [7:0] rx_byte = {in_sh_q[6:0], si_s};
    wire byte_done = sclk_rise && (bit_cnt_q == sfp_pkg::SINGLE_LAST_BIT);
    wire [ADDR_W-1:0] addr_shift = {addr_q[ADDR_W-9:0], rx_byte};
    wire [ADDR_W-1:0] rd_addr = (state_q == sfp_pkg::ST_ADDR) ? addr_shift : addr_q;
    wire enter_data = byte_done && (state_d == sfp_pkg::ST_DATA) && (state_q != sfp_pkg::ST_DATA);
    wire enter_stat = byte_done && (state_d == sfp_pkg::ST_STAT);
    wire in_output = (state_q == sfp_pkg::ST_DATA) || (state_q == sfp_pkg::ST_STAT);
    wire [2:0] out_last = dual_q ? sfp_pkg::DUAL_LAST_PAIR : sfp_pkg::SINGLE_LAST_BIT;
    wire exec = cs_rise && (state_q == sfp_pkg::ST_DONE);
    wire hard_guard = lock_q && !wp_n_s;
    wire [7:0] status_now;
    assign status_now = {lock_q, {(7 - sfp_pkg::STAT_GUARD_LSB - BP_BITS){1'b0}},
                         guard_q, arm_q, busy_q};
    wire fast_op = (rx_byte == sfp_pkg::OP_FAST_READ) || (rx_byte == sfp_pkg::OP_DUAL_OUT_READ);

    // Guarded blocks are the top 2^(g-1) blocks of the array
    function automatic logic [NBLK_W:0] guard_floor(input logic [BP_BITS-1:0] g);
        logic [NBLK_W:0] total;
        total = {1'b1, {NBLK_W{1'b0}}};
        if (g == '0)
            guard_floor = total;
        else if (int'(g) - 1 >= NBLK_W)
            guard_floor = '0;
        else
            guard_floor = total - ((NBLK_W+1)'(1) << (g - 1'b1));
    endfunction

    wire [NBLK_W:0] blk_idx = {1'b0, addr_q[ADDR_W-1:sfp_pkg::BLOCK_LSB]};
    wire area_guarded = blk_idx >= guard_floor(guard_q);
    wire erase_blocked = (job_q == sfp_pkg::JOB_CHIP) ? (guard_q != '0) : area_guarded;
    wire [ADDR_W-1:0] er_lo = (job_q == sfp_pkg::JOB_SECTOR) ? (addr_q & ~SECT_MASK) :
                              (job_q == sfp_pkg::JOB_BLOCK) ? (addr_q & ~BLK_MASK) : '0;
    wire [ADDR_W-1:0] er_hi = (job_q == sfp_pkg::JOB_SECTOR) ? (addr_q | SECT_MASK) :
                              (job_q == sfp_pkg::JOB_BLOCK) ? (addr_q | BLK_MASK) : '1;
    wire erase_job = (job_q == sfp_pkg::JOB_SECTOR) || (job_q == sfp_pkg::JOB_BLOCK) ||
                     (job_q == sfp_pkg::JOB_CHIP);

    // ------------------------------------------------------------------
    // Command state machine
    // ------------------------------------------------------------------
    always_comb
    begin
        state_d = state_q;
        job_d = job_q;
        fast_d = fast_q;
        dual_d = dual_q;
        if (byte_done)
        begin
            case (state_q)
                sfp_pkg::ST_CMD:
                begin
                    job_d = sfp_pkg::JOB_NONE;
                    fast_d = 1'b0;
                    dual_d = 1'b0;
                    state_d = sfp_pkg::ST_IGNORE;
                    if (rx_byte == sfp_pkg::OP_STATUS_READ)
                        state_d = sfp_pkg::ST_STAT;
                    else if (rx_byte == sfp_pkg::OP_READ)
                        state_d = sfp_pkg::ST_ADDR;
                    else if (busy_q)
                        state_d = sfp_pkg::ST_IGNORE;
                    else if (fast_op)
                    begin
                        fast_d = 1'b1;
                        dual_d = (rx_byte == sfp_pkg::OP_DUAL_OUT_READ);
                        state_d = sfp_pkg::ST_ADDR;
                    end
                    else if (rx_byte == sfp_pkg::OP_WRITE_ARM)
                    begin
                        job_d = sfp_pkg::JOB_ARM;
                        state_d = sfp_pkg::ST_DONE;
                    end
                    else if (rx_byte == sfp_pkg::OP_WRITE_DISARM)
                    begin
                        job_d = sfp_pkg::JOB_DISARM;
                        state_d = sfp_pkg::ST_DONE;
                    end
                    else if (rx_byte == sfp_pkg::OP_STATUS_WRITE)
                    begin
                        job_d = sfp_pkg::JOB_STATUS;
                        state_d = sfp_pkg::ST_SRIN;
                    end
                    else if (rx_byte == sfp_pkg::OP_SECTOR_ERASE)
                    begin
                        job_d = sfp_pkg::JOB_SECTOR;
                        state_d = sfp_pkg::ST_ADDR;
                    end
                    else if (rx_byte == sfp_pkg::OP_BLOCK_ERASE)
                    begin
                        job_d = sfp_pkg::JOB_BLOCK;
                        state_d = sfp_pkg::ST_ADDR;
                    end
                    else if (rx_byte == sfp_pkg::OP_CHIP_ERASE)
                    begin
                        job_d = sfp_pkg::JOB_CHIP;
                        state_d = sfp_pkg::ST_DONE;
                    end
                end
                sfp_pkg::ST_ADDR:
                begin
                    if (byte_cnt_q == sfp_pkg::ADDR_LAST_BYTE)
                    begin
                        if (job_q != sfp_pkg::JOB_NONE)
                            state_d = sfp_pkg::ST_DONE;
                        else if (fast_q)
                            state_d = sfp_pkg::ST_DUMMY;
                        else
                            state_d = sfp_pkg::ST_DATA;
                    end
                end
                sfp_pkg::ST_DUMMY: state_d = sfp_pkg::ST_DATA;
                sfp_pkg::ST_SRIN: state_d = sfp_pkg::ST_DONE;
                default: state_d = state_q;
            endcase
        end
        // Any bit past the final byte voids a write-type command
        if (sclk_rise && state_q == sfp_pkg::ST_DONE)
            state_d = sfp_pkg::ST_IGNORE;
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!NRST_IN || cs_n_s)
        begin
            state_q <= sfp_pkg::ST_CMD;
            job_q <= (!NRST_IN) ? sfp_pkg::JOB_NONE : job_q;
            fast_q <= 1'b0;
            dual_q <= 1'b0;
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 2'h0;
            in_sh_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            job_q <= job_d;
            fast_q <= fast_d;
            dual_q <= dual_d;
            if (sclk_rise)
            begin
                bit_cnt_q <= bit_cnt_q + 3'h1;
                in_sh_q <= rx_byte;
            end
            if (byte_done && state_q == sfp_pkg::ST_ADDR)
                byte_cnt_q <= byte_cnt_q + 2'h1;
        end
    end

    // ------------------------------------------------------------------
    // Read address and output shifter
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            addr_q <= '0;
            out_sh_q <= 8'h00;
            out_cnt_q <= 3'h0;
        end
        else if (byte_done && state_q == sfp_pkg::ST_ADDR && !enter_data)
            addr_q <= addr_shift;
        else if (enter_data)
        begin
            out_sh_q <= flash_array[rd_addr];
            addr_q <= rd_addr + 1'b1;
            out_cnt_q <= 3'h0;
        end
        else if (enter_stat)
        begin
            out_sh_q <= status_now;
            out_cnt_q <= 3'h0;
        end
        else if (sclk_fall && in_output)
        begin
            out_cnt_q <= (out_cnt_q == out_last) ? 3'h0 : out_cnt_q + 3'h1;
            if (out_cnt_q != out_last)
                out_sh_q <= dual_q ? {out_sh_q[5:0], 2'b00} : {out_sh_q[6:0], 1'b0};
            else if (state_q == sfp_pkg::ST_STAT)
                out_sh_q <= status_now;
            else
            begin
                out_sh_q <= flash_array[addr_q];
                addr_q <= addr_q + 1'b1;
            end
        end
    end

    // Pins change on the link's falling edge and are released while select is high
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!NRST_IN || cs_n_s)
        begin
            sio0_q <= 1'b0;
            sio1_q <= 1'b0;
            sio0_oe_n_q <= 1'b1;
            sio1_oe_n_q <= 1'b1;
        end
        else if (sclk_fall && in_output)
        begin
            sio1_q <= out_sh_q[7];
            sio1_oe_n_q <= 1'b0;
            sio0_q <= dual_q && out_sh_q[6];
            sio0_oe_n_q <= !dual_q;
        end
    end

    // ------------------------------------------------------------------
    // Status bits and self-timed cycles
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK_IN)
    begin
        if (!NRST_IN)
        begin
            lock_q <= sfp_pkg::RST_LOCK;
            guard_q <= '0;
            arm_q <= sfp_pkg::RST_ARM;
            busy_q <= 1'b0;
            er_wr_q <= 1'b0;
            er_ptr_q <= '0;
            er_end_q <= '0;
            hard_q <= 1'b0;
        end
        else
        begin
            hard_q <= hard_guard;
            if (exec && job_q == sfp_pkg::JOB_ARM)
                arm_q <= 1'b1;
            else if (exec && job_q == sfp_pkg::JOB_DISARM)
                arm_q <= 1'b0;
            else if (exec && job_q == sfp_pkg::JOB_STATUS && arm_q && !hard_guard)
            begin
                lock_q <= in_sh_q[sfp_pkg::STAT_LOCK_POS];
                guard_q <= in_sh_q[sfp_pkg::STAT_GUARD_LSB +: BP_BITS];
                busy_q <= 1'b1;
                er_wr_q <= 1'b0;
                er_ptr_q <= '0;
                er_end_q <= SRW_LAST;
            end
            else if (exec && erase_job && arm_q && !erase_blocked)
            begin
                busy_q <= 1'b1;
                er_wr_q <= 1'b1;
                er_ptr_q <= er_lo;
                er_end_q <= er_hi;
            end
            else if (busy_q)
            begin
                er_ptr_q <= er_ptr_q + 1'b1;
                if (er_ptr_q == er_end_q)
                begin
                    busy_q <= 1'b0;
                    arm_q <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN)
    begin
        if (busy_q && er_wr_q)
            flash_array[er_ptr_q] <= sfp_pkg::ERASED_BYTE;
    end

    assign SIO0_OUT = sio0_q;
    assign SIO0_OE_N_OUT = sio0_oe_n_q;
    assign SIO1_OUT = sio1_q;
    assign SIO1_OE_N_OUT = sio1_oe_n_q;
    assign LOCK_BIT_OUT = lock_q;
    assign GUARD_BITS_OUT = guard_q;
    assign ARM_LATCH_OUT = arm_q;
    assign BUSY_OUT = busy_q;
    assign HARD_GUARD_OUT = hard_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    status_accept_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (exec && job_q == sfp_pkg::JOB_STATUS && arm_q && !hard_guard)
        |=> busy_q && arm_q && lock_q == $past(in_sh_q[sfp_pkg::STAT_LOCK_POS]))
        else $error("accepted status write did not update");
    status_reject_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (exec && job_q == sfp_pkg::JOB_STATUS && lock_q && !wp_n_s)
        |=> $stable(lock_q) && $stable(guard_q) && !busy_q)
        else $error("status write went through under hard guard");
    cycle_end_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        $fell(busy_q) |-> !arm_q && $past(er_ptr_q == er_end_q))
        else $error("cycle ended early or latch kept");
    chip_gate_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (exec && job_q == sfp_pkg::JOB_CHIP && guard_q != '0 && !busy_q)
        |=> !busy_q && arm_q == $past(arm_q))
        else $error("chip erase ran with guard bits set");
    guard_erase_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (exec && (job_q == sfp_pkg::JOB_SECTOR || job_q == sfp_pkg::JOB_BLOCK)
         && area_guarded && !busy_q) |=> !busy_q [*2] ##0 $stable(arm_q))
        else $error("guarded area erase started");
    busy_reject_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (byte_done && state_q == sfp_pkg::ST_CMD && busy_q && fast_op && !cs_n_s)
        |=> state_q == sfp_pkg::ST_IGNORE)
        else $error("fast read accepted while busy");
    extra_bit_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (sclk_rise && state_q == sfp_pkg::ST_DONE) |=> !exec [*2])
        else $error("command executed after extra bit");
    addr_wrap_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (enter_data && rd_addr == '1) |=> addr_q == '0)
        else $error("read address did not wrap");
    dual_pins_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        !sio0_oe_n_q |-> dual_q && state_q == sfp_pkg::ST_DATA)
        else $error("second data pin driven outside dual read");
    sector_span_a: assert property (@(posedge CORE_CLK_IN) disable iff (!NRST_IN)
        (exec && erase_job && job_q != sfp_pkg::JOB_CHIP && arm_q && !erase_blocked && !busy_q)
        |=> (er_end_q - er_ptr_q) == ($past(job_q) == sfp_pkg::JOB_SECTOR ? SECT_MASK : BLK_MASK))
        else $error("erase span wrong size");

endmodule

// *** test/sfp_host_model.sv ***
// Host side of the flash link: drives select, link clock and command bits.
// Assumes SPI mode 0 and a core clock eight times the link bit rate.
`timescale 1ns/1ps

module sfp_host_model (
    input wire logic clk_in,
    input wire logic io0_in,
    input wire logic io1_in,
    input wire logic io0_oe_n_in,
    input wire logic io1_oe_n_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out
);
    // ------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------
    logic oe0_seen;
    logic oe1_seen;

    initial
    begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        mosi_out = 1'b0;
    end

    task automatic half();
        repeat (4) @(posedge clk_in);
    endtask

    // Sends nb bits of tx MSB first, then clocks nrd read cycles
    task automatic xfer(input logic [39:0] tx, input int nb, input int nrd, input bit dual,
                        output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        oe0_seen = 1'b0;
        oe1_seen = 1'b0;
        @(posedge clk_in);
        cs_n_out <= 1'b0;
        for (i = 0; i < nb + nrd; i++)
        begin
            // Released line toggles so a stale bit cannot pass for data
            mosi_out <= (i < nb) ? tx[39 - i] : ~mosi_out;
            half();
            sclk_out <= 1'b1;
            if (i >= nb)
                rx = dual ? {rx[13:0], io1_in, io0_in} : {rx[14:0], io1_in};
            oe0_seen = oe0_seen | ~io0_oe_n_in;
            oe1_seen = oe1_seen | ~io1_oe_n_in;
            half();
            sclk_out <= 1'b0;
        end
        half();
        cs_n_out <= 1'b1;
        repeat (8) @(posedge clk_in);
    endtask
endmodule

// *** test/sfp_tb.sv ***
// Self-checking bench of the flash core with a host link model.
// Assumes a small array (17 address bits, two blocks) so erases stay short.
`timescale 1ns/1ps

module tb;
    // ------------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------------
    logic clk = 1'b0;
    logic nrst;
    logic wp_n;
    logic cs_n, sclk, mosi, so0, oe0_n, so1, oe1_n, lock, arm, busy, hard;
    logic [2:0] guard;
    logic [15:0] rx;
    wire io0;
    int fail_count = 0;
    int n_checks = 0;

    assign io0 = oe0_n ? mosi : so0;
    always #10 clk = ~clk;

    sfp_flash_core #(.ADDR_W(17), .BP_BITS(3)) dut (.CORE_CLK_IN(clk), .NRST_IN(nrst),
        .CS_N_IN(cs_n), .SCLK_IN(sclk), .SIO0_IN(io0), .WP_N_IN(wp_n), .SIO0_OUT(so0),
        .SIO0_OE_N_OUT(oe0_n), .SIO1_OUT(so1), .SIO1_OE_N_OUT(oe1_n), .LOCK_BIT_OUT(lock),
        .GUARD_BITS_OUT(guard), .ARM_LATCH_OUT(arm), .BUSY_OUT(busy), .HARD_GUARD_OUT(hard));

    sfp_host_model host (.clk_in(clk), .io0_in(io0), .io1_in(so1), .io0_oe_n_in(oe0_n),
        .io1_oe_n_in(oe1_n), .cs_n_out(cs_n), .sclk_out(sclk), .mosi_out(mosi));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic send(input logic [39:0] tx, input int nb);
        host.xfer(tx, nb, 0, 1'b0, rx);
    endtask

    task automatic arm_it();
        send({sfp_pkg::OP_WRITE_ARM, 32'h0}, 8);
        check("arm", arm, 1'b1);
    endtask

    task automatic wait_free(input int lim);
        int k;
        for (k = 0; k < lim && busy !== 1'b0; k++)
            @(posedge clk);
        check("busy end", busy, 1'b0);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_lock_clear();
        wp_n <= 1'b0;
        arm_it();
        send({sfp_pkg::OP_STATUS_WRITE, 8'h87, 24'h0}, 16);
        check("sw busy", busy, 1'b1);
        wait_free(200);
        check("lock", lock, 1'b1);
        check("hard", hard, 1'b1);
        host.xfer({sfp_pkg::OP_STATUS_READ, 32'h0}, 8, 8, 1'b0, rx);
        check("status", rx[7:0], 8'h84);
        check("single out", host.oe0_seen, 1'b0);
    endtask

    task automatic t_refuse();
        logic [39:0] ops [3];
        int j;
        ops = '{{sfp_pkg::OP_SECTOR_ERASE, 32'h01F12300},
                {sfp_pkg::OP_BLOCK_ERASE, 32'h01F12300}, {sfp_pkg::OP_CHIP_ERASE, 32'h0}};
        arm_it();
        send({sfp_pkg::OP_STATUS_WRITE, 32'h0}, 16);
        check("locked", lock, 1'b1);
        check("sw refused", busy, 1'b0);
        for (j = 0; j < 3; j++)
        begin
            send(ops[j], (j == 2) ? 8 : 32);
            check("guarded", busy, 1'b0);
            check("arm kept", arm, 1'b1);
        end
    endtask

    task automatic t_unlock();
        wp_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("hard off", hard, 1'b0);
        send({sfp_pkg::OP_STATUS_WRITE, 32'h0}, 16);
        wait_free(200);
        check("unlock", {lock, guard}, 4'h0);
        check("arm off", arm, 1'b0);
    endtask

    task automatic t_erase();
        arm_it();
        send({sfp_pkg::OP_SECTOR_ERASE, 32'h000ABC00}, 33);
        check("cut frame", {busy, arm}, 2'h1);
        send({sfp_pkg::OP_SECTOR_ERASE, 32'h000ABC00}, 32);
        check("busy", busy, 1'b1);
        host.xfer({sfp_pkg::OP_STATUS_READ, 32'h0}, 8, 8, 1'b0, rx);
        check("busy read", rx[7:0], 8'h03);
        host.xfer({sfp_pkg::OP_FAST_READ, 32'h0}, 40, 8, 1'b0, rx);
        check("fast busy", host.oe1_seen, 1'b0);
        host.xfer({sfp_pkg::OP_DUAL_OUT_READ, 32'h0}, 40, 4, 1'b1, rx);
        check("dual busy", host.oe1_seen, 1'b0);
        wait_free(5000);
        check("arm done", arm, 1'b0);
        arm_it();
        send({sfp_pkg::OP_SECTOR_ERASE, 32'h01F00000}, 32);
        wait_free(5000);
    endtask

    task automatic t_read();
        logic [15:0] ff;
        ff = {sfp_pkg::ERASED_BYTE, sfp_pkg::ERASED_BYTE};
        host.xfer({sfp_pkg::OP_READ, 32'h000FFE00}, 32, 16, 1'b0, rx);
        check("read", rx, ff);
        check("read drive", host.oe1_seen, 1'b1);
        host.xfer({sfp_pkg::OP_READ, 32'h01FFFF00}, 32, 16, 1'b0, rx);
        check("wrap", rx, ff);
        host.xfer({sfp_pkg::OP_FAST_READ, 32'h000FFE00}, 40, 16, 1'b0, rx);
        check("fast", rx, ff);
        check("fast single", host.oe0_seen, 1'b0);
        host.xfer({sfp_pkg::OP_DUAL_OUT_READ, 32'h000FFE00}, 40, 8, 1'b1, rx);
        check("dual", rx, ff);
        check("dual pin", host.oe0_seen, 1'b1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        wp_n = 1'b1;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        t_lock_clear();
        t_refuse();
        t_unlock();
        t_erase();
        t_read();
        test_done();
    end

    initial
    begin
        #800000;
        fail_count++;
        test_done();
    end
endmodule
